// *** hdl/tdd_pkg.sv ***
// Operation
// - a context descriptor is one 64-byte block, decoded as a unit
// - the sub flow id picks which context descriptor applies
// - intermediate address size counts only with the 64-bit table format
// - lower granule size counts only with the 64-bit table format
// - lower table walks happen only while lower walk disable is 0
// - lower range stage-1 walks start at the lower table base
// - stage-1 walks carry the descriptor's inner and outer cacheability
// - stage-1 walks carry the shareability code, 10 meaning inner
// - upper table walks only with split spaces and upper walk enabled
// - stage-1 entries are read in the descriptor's table byte order
// - only context descriptors with valid bit 1 are used
// - a stream entry is one 64-byte block picked by flow id
// - configuration 000 passes nothing and aborts the requester
// - 100 bypass, 101 stage-1, 110 stage-2, 111 both stages
// - count 0 means one descriptor; above 0 a table per format (the code indexes every format linearly, 64 bytes apart)
// - context pointer is intermediate with stage 2, physical otherwise
// - stage-2 granule 00 is 4 KB, 01 64 KB, 10 16 KB
// - stage-2 walk cacheability and shareability codes decoded as given
// - stage-2 walks start at its base, tagged with the vm tag
// - stage-2 access flag faults suppressed when the disable bit is set
// - enable bit set after tables filled; acknowledge reads 1 when done
// - a stream entry with valid bit 0 is never used
`default_nettype none
package tdd_pkg;
  // apb register map, byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_ACK = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h008;
  localparam logic [3:0] TBL_STE = 4'h1; // paddr[11:8] of stream table window
  localparam logic [3:0] TBL_CD = 4'h2; // paddr[11:8] of context table window
  localparam int ENTRY_BYTES = 64;
  localparam int ENTRY_WORDS = ENTRY_BYTES / 4;
  localparam int ID_W = 2;
  localparam int N_ENTRIES = 1 << ID_W;
  localparam int MEM_WORDS = N_ENTRIES * ENTRY_WORDS;
  localparam int CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // internal state clear after enable
  localparam int PREP_NS = 80;
  localparam int CLK_NS = 5;
  localparam logic [4:0] PREP_CYCLES = 5'((PREP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic SPLIT_SUPPORTED = 1'b1;
  // stream entry configuration codes
  localparam logic [2:0] CFG_ABORT = 3'h0;
  localparam logic [2:0] CFG_BYPASS = 3'h4;
  localparam logic [2:0] CFG_S1 = 3'h5;
  localparam logic [2:0] CFG_S2 = 3'h6;
  localparam logic [2:0] CFG_BOTH = 3'h7;
  localparam logic [1:0] SHARE_INNER = 2'h2;
  // word indices inside a 64-byte entry
  localparam logic [3:0] W_STE_CTRL = 4'h0;
  localparam logic [3:0] W_STE_CTXPTR = 4'h1;
  localparam logic [3:0] W_STE_S2 = 4'h2;
  localparam logic [3:0] W_STE_S2BASE = 4'h3;
  localparam logic [3:0] W_CD_CTRL = 4'h0;
  localparam logic [3:0] W_CD_LBASE = 4'h1;
  localparam logic [3:0] W_CD_UBASE = 4'h2;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_PREP = 3'b010,
    ST_ON = 3'b100
  } tdd_state_e;

  typedef enum logic [2:0] {
    FLT_NONE = 3'h0,
    FLT_DISABLED = 3'h1,
    FLT_STE_INVALID = 3'h2,
    FLT_ABORT = 3'h3,
    FLT_BAD_CFG = 3'h4,
    FLT_CD_INVALID = 3'h5,
    FLT_SUB_RANGE = 3'h6
  } tdd_fault_e;

  // stream entry word 0, msb first
  typedef struct packed {
    logic [20:0] rsvd;
    logic [4:0] context_count_field;
    logic [1:0] context_table_format;
    logic [2:0] config_code;
    logic valid;
  } tdd_ste_ctrl_s;

  // stream entry word 2
  typedef struct packed {
    logic [1:0] rsvd;
    logic stage2_af_fault_disable;
    logic stage2_endianness;
    logic stage2_format_select;
    logic [1:0] stage2_shareability;
    logic [1:0] stage2_outer_cacheability;
    logic [1:0] stage2_inner_cacheability;
    logic [1:0] stage2_granule;
    logic [2:0] stage2_phys_size;
    logic [15:0] stage2_vm_tag;
  } tdd_ste_s2_s;

  // context descriptor word 0
  typedef struct packed {
    logic [14:0] rsvd;
    logic shared_asid_select;
    logic [2:0] intermediate_addr_size;
    logic table_endianness;
    logic [1:0] walk_shareability;
    logic [1:0] walk_outer_cacheability;
    logic [1:0] walk_inner_cacheability;
    logic [1:0] lower_granule_size;
    logic upper_walk_disable;
    logic lower_walk_disable;
    logic table_format_select;
    logic valid;
  } tdd_cd_ctrl_s;

  typedef struct packed {
    logic valid;
    logic [ID_W-1:0] flow_id;
    logic [ID_W-1:0] sub_flow_id;
  } tdd_req_s;

  typedef struct packed {
    logic valid;
    logic abort;
    tdd_fault_e fault;
    logic s1_en;
    logic s2_en;
    logic [31:0] context_addr;
    logic context_addr_is_ipa;
    logic [1:0] context_table_format;
    logic lower_walk_en;
    logic [31:0] lower_table_base;
    logic upper_walk_en;
    logic [31:0] upper_table_base;
    logic [1:0] lower_granule_size;
    logic [2:0] intermediate_addr_size;
    logic [1:0] walk_inner_cacheability;
    logic [1:0] walk_outer_cacheability;
    logic [1:0] walk_shareability;
    logic walk_inner_shareable;
    logic table_endianness;
    logic shared_asid_select;
    logic [31:0] stage2_table_base;
    tdd_ste_s2_s stage2;
    logic [16:0] stage2_granule_kb;
  } tdd_result_s;
endpackage
`default_nettype wire

// *** hdl/tdd_decoder.sv ***
// The APB slave port and the register offsets were chosen for this implementation.
`default_nettype none
module tdd_decoder
  import tdd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire tdd_req_s lookup_req,
  output tdd_result_s lookup_rsp
);

  // word address inside a descriptor table for the lookup; the bus indexes by paddr[7:2]
  function automatic logic [5:0] tbl_idx(input logic [ID_W-1:0] id, input logic [3:0] w);
    tbl_idx = {id, w};
  endfunction

  // stage-2 granule code to page size in kilobytes
  function automatic logic [16:0] granule_kb(input logic [1:0] code);
    case (code)
      2'h0: granule_kb = 17'd4;
      2'h1: granule_kb = 17'd64;
      2'h2: granule_kb = 17'd16;
      default: granule_kb = 17'd0;
    endcase
  endfunction

  logic [31:0] ste_mem [MEM_WORDS];
  logic [31:0] cd_mem [MEM_WORDS];
  logic [31:0] ctrl;
  tdd_state_e state;
  tdd_state_e next_state;
  logic [4:0] prep_cnt;
  logic [15:0] lookup_cnt;
  tdd_fault_e last_fault;

  // apb decode; zero wait states, so pready is always high
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire sel_ste = paddr[11:8] == TBL_STE;
  wire sel_cd = paddr[11:8] == TBL_CD;
  wire sel_ctrl = paddr == ADDR_CTRL;
  wire sel_ack = paddr == ADDR_ACK;
  wire sel_stat = paddr == ADDR_STAT;
  wire mapped = sel_ste || sel_cd || sel_ctrl || sel_ack || sel_stat;
  wire aligned = paddr[1:0] == 2'b00;
  wire [5:0] mem_idx = paddr[7:2];
  wire enabled = ctrl[CTRL_EN_BIT];
  wire ack_bit = state == ST_ON;
  assign pready = 1'b1;
  assign pslverr = access && !(mapped && aligned);

  // read mux; table words read back as written
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (sel_ctrl)
      rd_mux = ctrl;
    else if (sel_ack)
      rd_mux = {31'h0, ack_bit};
    else if (sel_stat)
      rd_mux = {lookup_cnt, 13'h0, last_fault};
    else if (sel_ste)
      rd_mux = ste_mem[mem_idx];
    else if (sel_cd)
      rd_mux = cd_mem[mem_idx];
  end
  assign prdata = (access && !pwrite && aligned) ? rd_mux : 32'h0000_0000;

  // control register; only the enable bit is writable
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl <= CTRL_RESET;
    else if (wr && sel_ctrl && aligned)
      ctrl <= {31'h0, pwdata[CTRL_EN_BIT]};
  end

  // descriptor tables; cleared at reset so every entry starts invalid
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < MEM_WORDS; i++)
      begin
        ste_mem[i] <= 32'h0000_0000;
        cd_mem[i] <= 32'h0000_0000;
      end
    end
    else if (wr && aligned)
    begin
      if (sel_ste)
        ste_mem[mem_idx] <= pwdata;
      if (sel_cd)
        cd_mem[mem_idx] <= pwdata;
    end
  end

  // enable handshake: stale decode state is flushed before acknowledging
  wire prep_done = prep_cnt == PREP_CYCLES;
  always_comb
  begin
    next_state = state;
    case (state)
      ST_OFF:
        if (enabled)
          next_state = ST_PREP;
      ST_PREP:
        if (!enabled)
          next_state = ST_OFF;
        else if (prep_done)
          next_state = ST_ON;
      ST_ON:
        if (!enabled)
          next_state = ST_OFF;
      default:
        next_state = ST_OFF;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_OFF;
      prep_cnt <= 5'h0;
    end
    else
    begin
      state <= next_state;
      prep_cnt <= (state == ST_PREP) ? prep_cnt + 5'h1 : 5'h0;
    end
  end

  // stream entry decode for the requested flow
  tdd_ste_ctrl_s ste_ctrl;
  tdd_ste_s2_s ste_s2;
  tdd_cd_ctrl_s cd_ctrl;
  logic [31:0] ctx_ptr;
  logic [ID_W-1:0] cd_sel;
  assign ste_ctrl = ste_mem[tbl_idx(lookup_req.flow_id, W_STE_CTRL)];
  assign ste_s2 = ste_mem[tbl_idx(lookup_req.flow_id, W_STE_S2)];
  assign ctx_ptr = ste_mem[tbl_idx(lookup_req.flow_id, W_STE_CTXPTR)];
  wire [2:0] cfg = ste_ctrl.config_code;
  wire cfg_ok = cfg == CFG_BYPASS || cfg == CFG_S1 || cfg == CFG_S2 || cfg == CFG_BOTH;
  wire s1_en = cfg == CFG_S1 || cfg == CFG_BOTH;
  wire s2_en = cfg == CFG_S2 || cfg == CFG_BOTH;
  wire single_cd = ste_ctrl.context_count_field == 5'h0;
  // a table of 2^count descriptors; wider ids than that are out of range
  wire [5:0] cd_span = 6'(6'h1 << ste_ctrl.context_count_field[2:0]);
  wire sub_ok = single_cd || ste_ctrl.context_count_field > 5'h2
    || {4'h0, lookup_req.sub_flow_id} < cd_span;
  assign cd_sel = single_cd ? '0 : lookup_req.sub_flow_id;
  assign cd_ctrl = cd_mem[tbl_idx(cd_sel, W_CD_CTRL)];
  wire is64 = cd_ctrl.table_format_select;

  // fault priority: disabled, invalid entry, abort, bad config, descriptor
  tdd_fault_e fault;
  always_comb
  begin
    fault = FLT_NONE;
    if (state != ST_ON)
      fault = FLT_DISABLED;
    else if (!ste_ctrl.valid)
      fault = FLT_STE_INVALID;
    else if (cfg == CFG_ABORT)
      fault = FLT_ABORT;
    else if (!cfg_ok)
      fault = FLT_BAD_CFG;
    else if (s1_en && !sub_ok)
      fault = FLT_SUB_RANGE;
    else if (s1_en && !cd_ctrl.valid)
      fault = FLT_CD_INVALID;
  end
  wire ok = fault == FLT_NONE;

  // assemble the decoded answer; fields are zero when their stage is off
  tdd_result_s res;
  always_comb
  begin
    res = '0;
    res.valid = lookup_req.valid;
    res.abort = !ok;
    res.fault = fault;
    res.s1_en = ok && s1_en;
    res.s2_en = ok && s2_en;
    if (ok && s1_en)
    begin
      // table entries sit 64 bytes apart
      res.context_addr = single_cd ? ctx_ptr
        : ctx_ptr + {24'h0, lookup_req.sub_flow_id, 6'h0};
      res.context_addr_is_ipa = s2_en;
      res.context_table_format = ste_ctrl.context_table_format;
      res.lower_walk_en = !cd_ctrl.lower_walk_disable;
      res.lower_table_base = cd_mem[tbl_idx(cd_sel, W_CD_LBASE)];
      res.upper_walk_en = SPLIT_SUPPORTED && !cd_ctrl.upper_walk_disable;
      res.upper_table_base = cd_mem[tbl_idx(cd_sel, W_CD_UBASE)];
      res.lower_granule_size = is64 ? cd_ctrl.lower_granule_size : 2'h0;
      res.intermediate_addr_size = is64 ? cd_ctrl.intermediate_addr_size : 3'h0;
      res.walk_inner_cacheability = cd_ctrl.walk_inner_cacheability;
      res.walk_outer_cacheability = cd_ctrl.walk_outer_cacheability;
      res.walk_shareability = cd_ctrl.walk_shareability;
      res.walk_inner_shareable = cd_ctrl.walk_shareability == SHARE_INNER;
      res.table_endianness = cd_ctrl.table_endianness;
      res.shared_asid_select = cd_ctrl.shared_asid_select;
    end
    if (ok && s2_en)
    begin
      res.stage2_table_base = ste_mem[tbl_idx(lookup_req.flow_id, W_STE_S2BASE)];
      res.stage2 = ste_s2;
      res.stage2.rsvd = 2'h0;
      res.stage2_granule_kb = granule_kb(ste_s2.stage2_granule);
    end
  end

  // answer is registered one cycle after the request
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      lookup_rsp <= '0;
    else
      lookup_rsp <= res;
  end

  // status: lookup count and the fault of the latest lookup
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lookup_cnt <= 16'h0;
      last_fault <= FLT_NONE;
    end
    else if (lookup_req.valid)
    begin
      lookup_cnt <= lookup_cnt + 16'h1;
      last_fault <= fault;
    end
  end

endmodule
`default_nettype wire

// *** dv/tdd_assertions.sv ***
`default_nettype none
module tdd_assertions
  import tdd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire tdd_req_s lookup_req,
  input wire tdd_result_s lookup_rsp
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic en;
  logic [4:0] cnt;
  // access decode for the control and acknowledge words
  wire acc = psel && penable;
  wire ack_rd = acc && !pwrite && paddr == ADDR_ACK;
  wire ctl_wr = acc && pwrite && paddr == ADDR_CTRL;
  wire rv = lookup_rsp.valid;
  wire [1:0] g = lookup_rsp.stage2.stage2_granule;
  wire [16:0] kb = g == 2'h0 ? 17'h4 : g == 2'h1 ? 17'h40 : g == 2'h2 ? 17'h10 : 17'h0;
  // edges since the last control write; saturates so idle time never wraps
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      en <= 1'b0;
      cnt <= 5'h1f;
    end
    else if (ctl_wr)
    begin
      en <= pwdata[CTRL_EN_BIT];
      cnt <= 5'h0;
    end
    else if (cnt != 5'h1f)
      cnt <= cnt + 5'h1;
  a_rsp_pulse: assert property (rv == $past(lookup_req.valid))
    else $error("lookup answer not one cycle after request");
  a_fault_abort: assert property (rv && lookup_rsp.fault != FLT_NONE |-> lookup_rsp.abort)
    else $error("fault without abort");
  a_invalid_quiet: assert property (rv && lookup_rsp.fault == FLT_STE_INVALID
    |-> !lookup_rsp.s1_en && !lookup_rsp.s2_en) else $error("invalid entry used");
  a_ptr_kind: assert property (rv && lookup_rsp.s1_en && !lookup_rsp.abort
    |-> lookup_rsp.context_addr_is_ipa == lookup_rsp.s2_en) else $error("pointer kind");
  a_share_inner: assert property (rv && lookup_rsp.s1_en
    |-> lookup_rsp.walk_inner_shareable == (lookup_rsp.walk_shareability == SHARE_INNER))
    else $error("inner shareable flag wrong");
  a_granule_size: assert property (rv && lookup_rsp.s2_en |-> lookup_rsp.stage2_granule_kb == kb)
    else $error("stage-2 granule size wrong");
  // one edge into prep, sixteen counting, one more to on: ack first seen at count 18
  a_ack_early: assert property (ack_rd && en && cnt < 5'd18 |-> !prdata[0])
    else $error("acknowledge too early");
  a_ack_set: assert property (ack_rd && en && cnt >= 5'd18 |-> prdata[0])
    else $error("acknowledge missing");
  a_ack_off: assert property (ack_rd && !en && cnt >= 5'h1 |-> !prdata[0])
    else $error("acknowledge stuck after disable");
  c_both: cover property (rv && lookup_rsp.s1_en && lookup_rsp.s2_en);
  c_ack: cover property (ack_rd && prdata[0]);
  c_err: cover property (acc && pslverr);
endmodule
bind tdd_decoder tdd_assertions u_chk (.mclk(mclk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .lookup_req(lookup_req), .lookup_rsp(lookup_rsp));
`default_nettype wire

// *** dv/tdd_host.sv ***
`default_nettype none
module tdd_host
(
  input wire logic mclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
  end
  // one transfer; waits an edge first so a release never meets the next setup
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a; // released lines must not look like the last request
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
`default_nettype none
module testbench
  import tdd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  tdd_req_s req;
  tdd_result_s rsp;
  tdd_fault_e fx;
  logic [2:0] c;
  logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h4, 3'h6, 3'h5, 3'h7};
  int failures = 0;
  int n_tests = 0;
  // free-running 200 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  tdd_decoder u_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lookup_req(req), .lookup_rsp(rsp));
  tdd_host u_host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a);
    u_host.xfer(1'b0, a, 32'h0, q, e);
  endtask
  // one lookup; the answer stands only in the cycle after the request
  task automatic look(input logic [1:0] f, input logic [1:0] s, input logic ab,
    input tdd_fault_e flt, input logic [1:0] st);
    @(posedge mclk);
    req <= '{valid: 1'b1, flow_id: f, sub_flow_id: s};
    @(posedge mclk);
    req.valid <= 1'b0;
    #1;
    chk({25'h0, rsp.valid, rsp.abort, rsp.fault, ab ? 2'h0 : {rsp.s1_en, rsp.s2_en}},
      {25'h0, 1'b1, ab, flt, st});
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // hang guard, far beyond the hundred or so cycles the sequence needs
  initial
  begin
    #20us;
    failures++;
    print_verdict();
  end
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    req = '0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    look(2'h1, 2'h0, 1'b1, FLT_DISABLED, 2'h0);
    rd(ADDR_CTRL);
    chk(q, CTRL_RESET);
    rd(12'h0fc);
    chk({31'h0, e}, 32'h1);
    wr(12'h200, 32'h0000_0813);
    wr(12'h204, 32'h1000_0000);
    wr(12'h148, 32'h0008_0005);
    wr(12'h14c, 32'h2000_0000);
    wr(12'h144, 32'h8000_0000);
    wr(12'h140, 32'h0000_004b);
    wr(ADDR_CTRL, 32'h1);
    rd(ADDR_ACK);
    chk(q, 32'h0);
    for (int i = 0; i < 20 && q[0] !== 1'b1; i++)
      rd(ADDR_ACK);
    chk(q, 32'h1);
    look(2'h0, 2'h0, 1'b1, FLT_STE_INVALID, 2'h0);
    look(2'h1, 2'h1, 1'b1, FLT_CD_INVALID, 2'h0);
    look(2'h1, 2'h2, 1'b1, FLT_SUB_RANGE, 2'h0);
    // configuration codes 000, 001, 100, 110, 101 and 111, ending on both stages
    foreach (codes[i])
    begin
      c = codes[i];
      fx = c == 3'h0 ? FLT_ABORT : c[2] ? FLT_NONE : FLT_BAD_CFG;
      wr(12'h140, {21'h0, 5'h1, 2'h0, c, 1'b1});
      look(2'h1, 2'h0, ~c[2], fx, {c[2] & c[0], c[2] & c[1]});
    end
    chk(rsp.lower_table_base, 32'h1000_0000);
    chk({30'h0, rsp.walk_shareability}, 32'h2);
    chk({15'h0, rsp.stage2_granule_kb}, 32'h40);
    chk(rsp.stage2_table_base, 32'h2000_0000);
    chk({16'h0, rsp.stage2.stage2_vm_tag}, 32'h5);
    chk(rsp.context_addr, 32'h8000_0000);
    wr(12'h200, 32'h0000_0815);
    look(2'h1, 2'h0, 1'b0, FLT_NONE, 2'h3);
    chk({29'h0, rsp.lower_granule_size, rsp.lower_walk_en}, 32'h0);
    wr(ADDR_CTRL, 32'h0);
    rd(ADDR_ACK);
    chk(q, 32'h0);
    // status: eleven lookups so far, the latest one clean
    rd(ADDR_STAT);
    chk({q[31:16], 13'h0, q[2:0]}, 32'h000b_0000);
    print_verdict();
  end
endmodule
`default_nettype wire
